// *** verilog/acc_pkg.sv ***
// Constants and types shared by the analog comparator control block.
package acc_pkg;

    // Register indices; the byte address on the bus is four times the index.
    localparam logic [2:0] ACC_IDX_CTRL = 3'h0;
    localparam logic [2:0] ACC_IDX_INSEL = 3'h2;
    localparam logic [2:0] ACC_IDX_REFLVL = 3'h4;
    localparam logic [2:0] ACC_IDX_INTEN = 3'h6;
    localparam logic [2:0] ACC_IDX_STATUS = 3'h7;
    localparam int ACC_IDX_SHIFT = 2;
    localparam int ACC_ADDR_W = 5;

    // Field positions in comparator_control.
    localparam int ACC_CTRL_ENABLE = 0;
    localparam int ACC_CTRL_HYS_LO = 1;
    localparam int ACC_CTRL_LOWPWR = 3;
    localparam int ACC_CTRL_EDGE_LO = 4;
    localparam int ACC_CTRL_PADOE = 6;
    localparam int ACC_CTRL_RUNSTBY = 7;

    // Field positions in input_select.
    localparam int ACC_INSEL_NEG_LO = 0;
    localparam int ACC_INSEL_POS_LO = 3;
    localparam int ACC_INSEL_INVERT = 7;

    // Field positions in interrupt_enable_reg and comparator_status.
    localparam int ACC_INTEN_CMP = 0;
    localparam int ACC_STAT_FLAG = 0;
    localparam int ACC_STAT_STATE = 4;

    // Writable bit masks of the control, input select and interrupt enable registers.
    localparam logic [7:0] ACC_CTRL_MASK = 8'hff;
    localparam logic [7:0] ACC_INSEL_MASK = 8'h9b;
    localparam logic [7:0] ACC_INTEN_MASK = 8'h01;

    // Reset values.
    localparam logic [7:0] ACC_CTRL_RST = 8'h00;
    localparam logic [7:0] ACC_INSEL_RST = 8'h00;
    localparam logic [7:0] ACC_REFLVL_RST = 8'hff;
    localparam logic [7:0] ACC_INTEN_RST = 8'h00;

    // Status state bit lags the comparator output by this many clocks.
    localparam int ACC_STATE_LAG = 3;

    // Edge selection codes.
    typedef enum logic [1:0] {
        ACC_EDGE_ANY = 2'h0,
        ACC_EDGE_RSVD = 2'h1,
        ACC_EDGE_FALL = 2'h2,
        ACC_EDGE_RISE = 2'h3
    } acc_edge_e;

    // Sleep state reported by the power manager.
    typedef enum logic [1:0] {
        ACC_SLP_ACTIVE = 2'h0,
        ACC_SLP_IDLE = 2'h1,
        ACC_SLP_STANDBY = 2'h3,
        ACC_SLP_PWRDOWN = 2'h2
    } acc_sleep_e;

endpackage : acc_pkg

// *** verilog/acc_top.sv ***
// Analog comparator digital control: registers, output path, event and interrupt.
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/10ps

// Functional notes
// R01: Comparator output is high only when positive input exceeds negative input.
// R02: Result is refreshed continuously and offered to software, events and pad.
// R03: Software sets pins, selects inputs, optional pad enable, then enable last.
// R04: Software ignores the output during the start-up time after enabling.
// R05: Software sets the pad's port direction to output while comparator is off.
// R06: Two-bit hysteresis field selects none or one of three levels.
// R07: Positive field picks one of four pins; negative picks three pins or reference.
// R08: Low-power bit selects reduced current with longer propagation delay.
// R09: Pad output enable routes the comparator output to its pin.
// R10: Flag is raised on rising, falling or both edges per edge select.
// R11: Interrupt request only when the interrupt enable bit is one.
// R12: Selected edge sets the compare flag whether or not interrupt enabled.
// R13: Request is high while enable and flag are set, until flag cleared.
// R14: One asynchronous level event follows the comparator output level.
// R15: The block takes no incoming events.
// R16: In idle sleep everything keeps working as in active mode.
// R17: Standby disables the comparator unless run-in-standby is set.
// R18: Power-down disables comparator and pad output regardless of settings.
// R19: Edge codes: 0 both, 2 falling, 3 rising, 1 reserved.
// R20: Writing one to the compare flag clears it; zero leaves it.
// R21: Status state bit follows the output through a three-cycle synchronizer.
// R22: Invert bit inverts the output before every consumer.
// R23: Edge detection compares current and previous synchronized samples.
// R24: Reserved offsets read zero and ignore writes; unused bits read zero.
module acc_top
    import acc_pkg::*;
(
    input wire logic pclk, // Peripheral clock, 20 MHz.
    input wire logic presetn, // Asynchronous reset, active low.
    input wire logic psel, // APB select.
    input wire logic penable, // APB access phase.
    input wire logic pwrite, // APB direction, high for write.
    input wire logic [31:0] paddr, // APB byte address.
    input wire logic [31:0] pwdata, // APB write data.
    input wire logic [3:0] pstrb, // APB byte strobes.
    output logic [31:0] prdata, // APB read data.
    output logic pready, // APB ready, always high.
    output logic pslverr, // APB error, always low.
    input wire logic [1:0] sleep_mode, // Sleep state from power manager.
    input wire logic analog_result, // Raw comparator decision, asynchronous.
    output logic analog_enable, // Powers the comparator core.
    output logic [1:0] hysteresis_select, // Hysteresis level to the core.
    output logic low_power_select, // Reduced-current mode to the core.
    output logic [1:0] positive_input_select, // Positive pin selection.
    output logic [1:0] negative_input_select, // Negative pin or reference selection.
    output logic [7:0] internal_reference_level, // Reference divider setting.
    output logic event_out, // Asynchronous level event.
    output logic pad_out, // Output pad data.
    output logic pad_oe, // Output pad enable.
    output logic irq // Interrupt request, level.
);

    logic [7:0] ctrl_q;
    logic [7:0] insel_q;
    logic [7:0] reflvl_q;
    logic [7:0] inten_q;
    logic flag_q;
    logic sync1_q;
    logic sync2_q;
    logic state_q;
    logic [31:0] prdata_q;
    logic wr_en;
    logic rd_setup;
    logic [2:0] reg_idx;
    logic addr_ok;
    logic core_active;
    logic out_level;
    logic edge_hit;
    logic clear_req;
    acc_sleep_e sleep;
    acc_edge_e edge_sel;

    // Register index is valid when it names one of the five mapped registers.
    function automatic logic idx_mapped(input logic [2:0] idx);
        idx_mapped = (idx == ACC_IDX_CTRL) || (idx == ACC_IDX_INSEL)
            || (idx == ACC_IDX_REFLVL) || (idx == ACC_IDX_INTEN)
            || (idx == ACC_IDX_STATUS);
    endfunction : idx_mapped

    assign sleep = acc_sleep_e'(sleep_mode);
    assign edge_sel = acc_edge_e'(ctrl_q[ACC_CTRL_EDGE_LO +: 2]);
    assign reg_idx = paddr[ACC_IDX_SHIFT +: 3];
    assign addr_ok = (paddr[1:0] == 2'h0) && (paddr[31:ACC_ADDR_W] == '0);
    assign wr_en = psel && penable && pwrite && addr_ok && pstrb[0];
    assign rd_setup = psel && !penable && !pwrite;
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign prdata = prdata_q;

    // The core runs when enabled unless sleep forbids it; idle keeps it as in active mode.
    always_comb begin
        unique case (sleep)
            ACC_SLP_ACTIVE, ACC_SLP_IDLE: core_active = ctrl_q[ACC_CTRL_ENABLE]; // [R16]
            ACC_SLP_STANDBY: core_active = ctrl_q[ACC_CTRL_ENABLE]
                && ctrl_q[ACC_CTRL_RUNSTBY]; // [R17]
            ACC_SLP_PWRDOWN: core_active = 1'b0; // [R18]
        endcase
    end

    // The analog core reports positive above negative as a one.
    assign out_level = core_active && (analog_result ^ insel_q[ACC_INSEL_INVERT]); // [R01] [R22]

    assign analog_enable = core_active; // [R02]
    assign hysteresis_select = ctrl_q[ACC_CTRL_HYS_LO +: 2]; // [R06]
    assign low_power_select = ctrl_q[ACC_CTRL_LOWPWR]; // [R08]
    assign positive_input_select = insel_q[ACC_INSEL_POS_LO +: 2]; // [R07]
    assign negative_input_select = insel_q[ACC_INSEL_NEG_LO +: 2]; // [R07]
    assign internal_reference_level = reflvl_q;

    // The event and pad are combinational so they work without the clock.
    assign event_out = out_level; // [R14]
    assign pad_out = out_level; // [R09]
    assign pad_oe = ctrl_q[ACC_CTRL_PADOE] && core_active; // [R09] [R18]

    // No event input exists on this block.
    // [R15]

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= ACC_CTRL_RST;
        end else if (wr_en && reg_idx == ACC_IDX_CTRL) begin
            ctrl_q <= pwdata[7:0] & ACC_CTRL_MASK;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            insel_q <= ACC_INSEL_RST;
        end else if (wr_en && reg_idx == ACC_IDX_INSEL) begin
            insel_q <= pwdata[7:0] & ACC_INSEL_MASK; // [R24]
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reflvl_q <= ACC_REFLVL_RST;
        end else if (wr_en && reg_idx == ACC_IDX_REFLVL) begin
            reflvl_q <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            inten_q <= ACC_INTEN_RST;
        end else if (wr_en && reg_idx == ACC_IDX_INTEN) begin
            inten_q <= pwdata[7:0] & ACC_INTEN_MASK; // [R11]
        end
    end

    // Two synchronizer stages then the status copy give the three-cycle lag.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            state_q <= 1'b0;
        end else begin
            sync1_q <= out_level;
            sync2_q <= sync1_q;
            state_q <= sync2_q; // [R21]
        end
    end

    // The status copy doubles as the previous sample for edge detection.
    always_comb begin
        unique case (edge_sel)
            ACC_EDGE_ANY: edge_hit = sync2_q != state_q; // [R19] [R23]
            ACC_EDGE_FALL: edge_hit = !sync2_q && state_q; // [R19] [R10]
            ACC_EDGE_RISE: edge_hit = sync2_q && !state_q; // [R19] [R10]
            ACC_EDGE_RSVD: edge_hit = 1'b0; // [R19]
        endcase
    end

    assign clear_req = wr_en && reg_idx == ACC_IDX_STATUS && pwdata[ACC_STAT_FLAG]; // [R20]

    // A new edge in the clearing cycle wins so no event is lost.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_q <= 1'b0;
        end else if (edge_hit) begin
            flag_q <= 1'b1; // [R12]
        end else if (clear_req) begin
            flag_q <= 1'b0; // [R20]
        end
    end

    assign irq = flag_q && inten_q[ACC_INTEN_CMP]; // [R11] [R13]

    // Read data is captured in the setup phase and shown during the access phase.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0000_0000;
        end else if (rd_setup) begin
            prdata_q <= 32'h0000_0000;
            if (addr_ok && idx_mapped(reg_idx)) begin
                unique case (reg_idx)
                    ACC_IDX_CTRL: prdata_q[7:0] <= ctrl_q;
                    ACC_IDX_INSEL: prdata_q[7:0] <= insel_q;
                    ACC_IDX_REFLVL: prdata_q[7:0] <= reflvl_q;
                    ACC_IDX_INTEN: prdata_q[7:0] <= inten_q;
                    ACC_IDX_STATUS: begin
                        prdata_q[ACC_STAT_STATE] <= state_q; // [R02]
                        prdata_q[ACC_STAT_FLAG] <= flag_q;
                    end
                    default: prdata_q[7:0] <= 8'h00; // [R24]
                endcase
            end
        end
    end

endmodule : acc_top

// *** tb/acc_analog_model.sv ***
// Behavioural analog front end: input pins, reference and comparator core.
`timescale 1ns/10ps
module acc_analog_model (
    input wire logic pclk, // Clock, only varies the unpowered output.
    input wire logic analog_enable, // Core power.
    input wire logic [1:0] positive_input_select, // Positive pin choice.
    input wire logic [1:0] negative_input_select, // Negative pin or reference.
    input wire logic [7:0] internal_reference_level, // Reference level.
    input wire logic [31:0] pos_mv, // Four positive pin levels, a byte each.
    input wire logic [23:0] neg_mv, // Three negative pin levels, a byte each.
    output logic analog_result // Raw decision.
);
    logic [7:0] vp;
    logic [7:0] vn;
    logic junk_q = 1'b0;
    // An unpowered core gives no valid decision, so it shows a changing level.
    always @(posedge pclk) junk_q <= !junk_q;
    assign vp = pos_mv[positive_input_select * 8 +: 8];
    assign vn = (negative_input_select == 2'h3) ? internal_reference_level
        : neg_mv[negative_input_select * 8 +: 8];
    assign analog_result = analog_enable ? (vp > vn) : junk_q;
endmodule : acc_analog_model

// *** tb/acc_assertions.sv ***
// Port-level properties of the analog comparator control block.
`timescale 1ns/10ps
module acc_checker
    import acc_pkg::*;
(
    input wire logic pclk, // Clock.
    input wire logic presetn, // Reset, active low.
    input wire logic psel, // Select.
    input wire logic penable, // Access phase.
    input wire logic pwrite, // Direction.
    input wire logic [31:0] paddr, // Address.
    input wire logic [31:0] pwdata, // Write data.
    input wire logic [3:0] pstrb, // Strobes.
    input wire logic [31:0] prdata, // Read data.
    input wire logic [1:0] sleep_mode, // Sleep state.
    input wire logic analog_enable, // Core power.
    input wire logic event_out, // Level event.
    input wire logic pad_out, // Pad data.
    input wire logic pad_oe, // Pad enable.
    input wire logic irq // Interrupt request.
);
    logic [5:0] ev_q;
    logic chg;
    logic wr_acc;
    logic rd_acc;
    logic inten_wr;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) ev_q <= 6'h0;
        else ev_q <= {ev_q[4:0], event_out};
    end
    // Any change of the output level within the last six clocks.
    assign chg = |(ev_q ^ {ev_q[4:0], event_out});
    assign wr_acc = psel && penable && pwrite && pstrb[0];
    assign rd_acc = psel && penable && !pwrite;
    assign inten_wr = wr_acc && paddr == 32'h18;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_clear;
        wr_acc && paddr == 32'h1c && pwdata[0] ##1 !chg;
    endsequence
    chk_pad_follows: assert property (pad_out == event_out)
        else $error("pad data differs from event");
    chk_oe_needs_core: assert property (pad_oe |-> analog_enable)
        else $error("pad enabled with core off");
    chk_pwrdown_off: assert property (sleep_mode == ACC_SLP_PWRDOWN
        |-> !analog_enable && !pad_oe)
        else $error("core or pad on in power-down");
    chk_event_gated: assert property (!analog_enable |-> !event_out)
        else $error("event high with core off");
    chk_irq_cause: assert property ($rose(irq) |-> chg || $past(inten_wr))
        else $error("request rose without cause");
    chk_flag_cleared: assert property (s_clear |-> !irq)
        else $error("request stayed after clear");
    chk_state_bit: assert property (rd_acc && paddr == 32'h1c && !chg
        |-> prdata[4] == event_out)
        else $error("state bit wrong");
    chk_rdata_clean: assert property (rd_acc |-> prdata[31:8] == 24'h0)
        else $error("upper read bits set");
    chk_rsvd_zero: assert property (rd_acc && paddr[4:2] inside {3'h1, 3'h3, 3'h5}
        |-> prdata == 32'h0)
        else $error("reserved offset read nonzero");
endmodule : acc_checker
bind acc_top acc_checker i_acc_checker (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .sleep_mode(sleep_mode), .analog_enable(analog_enable),
    .event_out(event_out), .pad_out(pad_out), .pad_oe(pad_oe), .irq(irq));

// *** tb/acc_top_bench.sv ***
// Self-checking bench for the analog comparator control block.
`timescale 1ns/10ps
module acc_top_bench
    import acc_pkg::*;
;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] paddr = 32'h0;
    logic [31:0] pwdata = 32'h0;
    logic [1:0] sleep_mode = 2'h0;
    logic [31:0] pos_mv = 32'h10;
    logic [23:0] neg_mv = 24'h80;
    logic [31:0] prdata;
    logic pready, err, ar, aen, lp, ev, po, oe, irq;
    logic pad_pin;
    logic [1:0] hy, ps, ns;
    logic [7:0] rl;
    int mismatches = 0;
    int comparisons = 0;
    always #25 pclk = ~pclk;
    // The port drives the pin low whenever the pad output is off, so it never floats.
    assign pad_pin = oe ? po : 1'b0;
    acc_top i_acc_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
        .pready(pready), .pslverr(err), .sleep_mode(sleep_mode), .analog_result(ar),
        .analog_enable(aen), .hysteresis_select(hy), .low_power_select(lp),
        .positive_input_select(ps), .negative_input_select(ns),
        .internal_reference_level(rl), .event_out(ev), .pad_out(po), .pad_oe(oe), .irq(irq));
    acc_analog_model i_acc_analog_model (.pclk(pclk), .analog_enable(aen),
        .positive_input_select(ps), .negative_input_select(ns), .internal_reference_level(rl),
        .pos_mv(pos_mv), .neg_mv(neg_mv), .analog_result(ar));
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : give_verdict
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    function automatic logic [31:0] ad(input logic [2:0] i);
        return {27'h0, i, 2'h0};
    endfunction : ad
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
        output logic [31:0] q);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) begin
            mismatches++;
            give_verdict();
        end
    endtask : apb
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] q;
        apb(1'b1, a, d, q);
    endtask : wr
    task automatic rd(input logic [31:0] a, input logic [31:0] e);
        logic [31:0] q;
        apb(1'b0, a, 32'h0, q);
        check(q, e);
    endtask : rd
    task automatic t_regs();
        rd(ad(ACC_IDX_CTRL), 32'h0);
        rd(ad(ACC_IDX_REFLVL), 32'hff);
        wr(ad(3'h5), 32'hff);
        rd(ad(3'h5), 32'h0);
        check(32'({pready, err}), 32'h2);
        wr(ad(ACC_IDX_INSEL), 32'hff);
        rd(ad(ACC_IDX_INSEL), 32'h9b);
        wr(ad(ACC_IDX_REFLVL), 32'h40);
        wr(ad(ACC_IDX_CTRL), 32'h0e);
        @(posedge pclk);
        check(32'({hy, lp, rl}), 32'h740);
    endtask : t_regs
    task automatic t_edges();
        logic r;
        logic f;
        for (int k = 0; k < 4; k++) begin
            r = (k == 0) || (k == 3);
            f = (k == 0) || (k == 2);
            wr(ad(ACC_IDX_INSEL), 32'h0);
            wr(ad(ACC_IDX_INTEN), 32'(k != 0));
            wr(ad(ACC_IDX_CTRL), {26'h0, 2'(k), 4'h1});
            wr(ad(ACC_IDX_STATUS), 32'h1);
            pos_mv <= 32'hf0;
            repeat (ACC_STATE_LAG + 2) @(posedge pclk);
            check(32'(irq), 32'(r && k != 0));
            rd(ad(ACC_IDX_STATUS), {27'h0, 1'b1, 3'h0, r});
            wr(ad(ACC_IDX_STATUS), 32'h1);
            pos_mv <= 32'h10;
            repeat (ACC_STATE_LAG + 2) @(posedge pclk);
            wr(ad(ACC_IDX_STATUS), 32'h0);
            rd(ad(ACC_IDX_STATUS), {31'h0, f});
        end
    endtask : t_edges
    task automatic t_invert();
        wr(ad(ACC_IDX_INSEL), 32'h93);
        pos_mv <= 32'h0030_0000;
        wr(ad(ACC_IDX_CTRL), 32'h41);
        @(posedge pclk);
        check(32'({ev, po, oe, ps, ns}), 32'h7b);
        pos_mv <= 32'h0050_0000;
        @(posedge pclk);
        check(32'({ev, po}), 32'h0);
        pos_mv <= 32'h0030_0000;
    endtask : t_invert
    task automatic t_sleep();
        logic on;
        for (int r = 0; r < 2; r++) begin
            wr(ad(ACC_IDX_CTRL), {24'h0, 1'(r), 7'h41});
            for (int m = 0; m < 4; m++) begin
                sleep_mode <= 2'(m);
                @(posedge pclk);
                on = (m < 2) || (m == 3 && r == 1);
                check(32'({aen, oe, ev, pad_pin}), 32'({4{on}}));
            end
            sleep_mode <= ACC_SLP_ACTIVE;
        end
    endtask : t_sleep
    task automatic t_reset();
        wr(ad(ACC_IDX_REFLVL), 32'h20);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        check(prdata, 32'h0);
        check(32'({irq, aen, oe, ev, rl}), 32'hff);
        presetn <= 1'b1;
        rd(ad(ACC_IDX_REFLVL), 32'hff);
        rd(ad(ACC_IDX_STATUS), 32'h0);
    endtask : t_reset
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_edges();
        t_invert();
        t_sleep();
        t_reset();
        give_verdict();
    end
endmodule : acc_top_bench
